// file: shared/spindle_pkg.sv
/*
  Constants, register map and state type for the spindle power sequencer.
  Assumes a single 25 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package spindle_pkg;

  localparam int unsigned AXI_AW = 8;

  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  STATUS_OFF = 8'h04;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;

  localparam int unsigned CTRL_REMOTE_BIT = 0;
  localparam int unsigned CTRL_START_BIT  = 1;
  localparam int unsigned STAT_STATE_LSB  = 0;
  localparam int unsigned STAT_OUT_LSB    = 8;
  localparam int unsigned STAT_PIN_LSB    = 20;

  localparam int unsigned PIN_W        = 12;
  localparam int unsigned PIN_START    = 0;
  localparam int unsigned PIN_SEQREQ   = 1;
  localparam int unsigned PIN_BREAKERS = 2;
  localparam int unsigned PIN_PACK     = 3;
  localparam int unsigned PIN_COVER    = 4;
  localparam int unsigned PIN_THERMAL  = 5;
  localparam int unsigned PIN_SPEED    = 6;
  localparam int unsigned PIN_LOADED   = 7;
  localparam int unsigned PIN_UNLOADED = 8;
  localparam int unsigned PIN_SUPPLY   = 9;
  localparam int unsigned SUPPLY_W     = 3;
  localparam int unsigned OUT_W        = 10;

  localparam longint unsigned CLK_HZ        = 25_000_000;
  localparam longint unsigned LOAD_DELAY_S  = 10;
  localparam longint unsigned BRAKE_TIME_S  = 30;
  localparam longint unsigned FLASH_HALF_MS = 250;

  localparam logic [31:0] LOAD_DELAY_CYC = 32'(CLK_HZ * LOAD_DELAY_S);
  localparam logic [31:0] BRAKE_CYC      = 32'(CLK_HZ * BRAKE_TIME_S);
  localparam logic [31:0] FLASH_CYC      = 32'(CLK_HZ * FLASH_HALF_MS / 1000);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPINUP,
    ST_LOADWAIT,
    ST_LOADING,
    ST_READY,
    ST_UNLOAD,
    ST_BRAKE
  } seq_state_e;

endpackage

// file: shared/timer_if.sv
/*
  Run, limit and expiry signals between the sequencer and a cycle timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface timer_if;
  logic        run;
  logic [31:0] limit;
  logic        done;
  modport ctl (output run, output limit, input done);
  modport tmr (input run, input limit, output done);
endinterface

// file: src/cycle_timer.sv
/*
  Cycle counter that pulses done once per limit cycles while run is high.
  Assumes limit is at least one and stays constant while run is high.
*/
`timescale 1ns/1ps
module cycle_timer (
  input wire logic clk,
  input wire logic rst_n,
  timer_if.tmr     tm
);

  logic [31:0] count_q;
  logic        done_q;
  wire         atEnd = (count_q == tm.limit - 32'h0000_0001);

  // The count clears whenever run drops, so each run starts from zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 32'h0000_0000;
      done_q  <= 1'b0;
    end else if (!tm.run) begin
      count_q <= 32'h0000_0000;
      done_q  <= 1'b0;
    end else if (atEnd) begin
      count_q <= 32'h0000_0000;
      done_q  <= 1'b1;
    end else begin
      count_q <= count_q + 32'h0000_0001;
      done_q  <= 1'b0;
    end
  end

  assign tm.done = done_q;

endmodule

// file: src/spindle_power_sequencer.sv
/*
  Spindle motor, brake, head load and retract sequencer with an AXI4-Lite
  register port.
  Assumes switch and sensor inputs are asynchronous and relay drivers
  follow the registered outputs.
*/
// Functional notes
// - Speed up: arm retract, start load delay
// - Start needs breakers, pack, closed cover
// - Load delay expiry starts head loading
// - Ready flashes at start-up, steady when loaded
// - Switch toggle or lost request powers off
// - Retraction drives heads back, ready flashes
// - Heads unloaded: stop retraction, release motor
// - Motor release enables braking sequence
// - Brake power first, then brake output
// - Speed loss drops retract output
// - Brakes release thirty seconds after braking
// - Brake release: lamp off, cover unlocked
// - Any supply loss drops retract output
// - Low speed starts emergency retract
// - Thermal overload removes motor power
// - No restart while thermal switch open
// - Power-on needs pack installed
// - Rotation needs cover closed
// - Cover locked while pack rotates
`timescale 1ns/1ps
module spindle_power_sequencer
  import spindle_pkg::*;
#(
  parameter logic [31:0] LOAD_CYC  = spindle_pkg::LOAD_DELAY_CYC,
  parameter logic [31:0] BRAKE_LEN = spindle_pkg::BRAKE_CYC,
  parameter logic [31:0] FLASH_LEN = spindle_pkg::FLASH_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic [spindle_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [spindle_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              startSw,
  input  wire logic                              seqPowerReq,
  input  wire logic                              breakersOk,
  input  wire logic                              packOn,
  input  wire logic                              coverClosed,
  input  wire logic                              thermalOk,
  input  wire logic                              speedSense,
  input  wire logic                              headsLoaded,
  input  wire logic                              headsUnloaded,
  input  wire logic [spindle_pkg::SUPPLY_W-1:0]  supplyGood,
  output logic                                   sequence_power_ctl,
  output logic                                   start_ctl,
  output logic                                   speed_ok,
  output logic                                   motor_ctl,
  output logic                                   brake_power_ctl,
  output logic                                   retract_ctl,
  output logic                                   brake_ctl,
  output logic                                   return_home_retract,
  output logic                                   headsLoadReq,
  output logic                                   readyLamp,
  output logic                                   coverLock
);

  import spindle_pkg::*;

  // Input synchronisation.
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;

  assign pinRaw = {supplyGood, headsUnloaded, headsLoaded, speedSense, thermalOk,
                   coverClosed, packOn, breakersOk, seqPowerReq, startSw};

  sync_bank #(.W(PIN_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pinRaw),
    .q     (pinSync)
  );

  wire                startS    = pinSync[PIN_START];
  wire                seqReqS   = pinSync[PIN_SEQREQ];
  wire                breakersS = pinSync[PIN_BREAKERS];
  wire                packS     = pinSync[PIN_PACK];
  wire                coverS    = pinSync[PIN_COVER];
  wire                thermalS  = pinSync[PIN_THERMAL];
  wire                speedS    = pinSync[PIN_SPEED];
  wire                loadedS   = pinSync[PIN_LOADED];
  wire                unloadedS = pinSync[PIN_UNLOADED];
  wire [SUPPLY_W-1:0] supplyS   = pinSync[PIN_SUPPLY +: SUPPLY_W];

  // Register state.
  logic        remoteMode_q;
  logic        softStart_q;
  logic        startPrev_q;
  logic        flash_q;
  seq_state_e  state_q;
  seq_state_e  state_d;

  // Timers.
  timer_if seqTmr ();
  timer_if flashTmr ();

  cycle_timer u_seq_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tm    (seqTmr.tmr)
  );

  cycle_timer u_flash_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tm    (flashTmr.tmr)
  );

  wire inLoadWait = (state_q == ST_LOADWAIT);
  wire inBrake    = (state_q == ST_BRAKE);

  // Both intervals are counted in system clock cycles.
  assign seqTmr.run     = inLoadWait | inBrake;
  assign seqTmr.limit   = inBrake ? BRAKE_LEN : LOAD_CYC;
  assign flashTmr.run   = 1'b1;
  assign flashTmr.limit = FLASH_LEN;

  // Sequence conditions.
  wire supplyAll  = &supplyS;
  wire startPress = (startS & ~startPrev_q) | softStart_q;
  // Local mode follows the +20Y supply; remote mode follows the controller.
  wire seqPower   = remoteMode_q ? seqReqS : supplyS[0];
  // Start needs breakers, pack, closed cover and a cool motor.
  wire startOk    = seqPower & breakersS & packS & coverS & thermalS;
  // A switch toggle, loss of request, pack or cover all begin power-off.
  wire stopReq    = startPress | ~seqPower | ~packS | ~coverS;
  // Lost speed or supply while heads may be out forces a retract.
  wire emergency  = ~speedS | ~supplyAll;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (startPress && startOk) begin
          state_d = ST_SPINUP;
        end
      end
      ST_SPINUP: begin
        if (stopReq || !thermalS) begin
          state_d = ST_UNLOAD;
        end else if (speedS) begin
          state_d = ST_LOADWAIT;
        end
      end
      ST_LOADWAIT: begin
        if (stopReq || emergency) begin
          state_d = ST_UNLOAD;
        end else if (seqTmr.done) begin
          state_d = ST_LOADING;
        end
      end
      ST_LOADING: begin
        if (stopReq || emergency) begin
          state_d = ST_UNLOAD;
        end else if (loadedS) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (stopReq || emergency) begin
          state_d = ST_UNLOAD;
        end
      end
      ST_UNLOAD: begin
        if (unloadedS) begin
          state_d = ST_BRAKE;
        end
      end
      ST_BRAKE: begin
        if (seqTmr.done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Output decode.
  wire runStart   = (state_q == ST_SPINUP) | inLoadWait | (state_q == ST_LOADING)
                  | (state_q == ST_READY);
  // Motor runs until heads are unloaded; a thermal trip removes it at once.
  wire motorOn    = (runStart | (state_q == ST_UNLOAD)) & thermalS;
  wire rotating   = runStart | (state_q == ST_UNLOAD) | inBrake;
  wire lampSteady = (state_q == ST_READY);
  wire lampFlash  = rotating & ~lampSteady;
  // Brake output rises one cycle after brake power and drops with it.
  wire brakeOn    = inBrake & brake_power_ctl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      startPrev_q <= 1'b0;
      flash_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      startPrev_q <= startS;
      flash_q     <= flashTmr.done ? ~flash_q : flash_q;
    end
  end

  // All relay and lamp outputs are registered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sequence_power_ctl  <= 1'b0;
      start_ctl           <= 1'b0;
      speed_ok            <= 1'b0;
      motor_ctl           <= 1'b0;
      brake_power_ctl     <= 1'b0;
      brake_ctl           <= 1'b0;
      retract_ctl         <= 1'b0;
      return_home_retract <= 1'b0;
      headsLoadReq        <= 1'b0;
      readyLamp           <= 1'b0;
      coverLock           <= 1'b0;
    end else begin
      sequence_power_ctl  <= seqPower;
      start_ctl           <= runStart;
      speed_ok            <= speedS;
      motor_ctl           <= motorOn;
      brake_power_ctl     <= inBrake;
      brake_ctl           <= brakeOn;
      retract_ctl         <= speedS & supplyAll;
      return_home_retract <= (state_q == ST_UNLOAD);
      headsLoadReq        <= (state_q == ST_LOADING);
      readyLamp           <= lampSteady | (lampFlash & flash_q);
      coverLock           <= rotating;
    end
  end

  // AXI4-Lite slave: one write and one read at a time.
  logic [AXI_AW-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;

  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire bDone    = s_axi_bvalid & s_axi_bready;
  wire wrFire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wrCtrl   = wrFire & (awAddr_q == CTRL_OFF);
  wire wrStatus = wrFire & (awAddr_q == STATUS_OFF);
  wire wrOk     = wrCtrl | wrStatus;
  wire arTake   = s_axi_arvalid & s_axi_arready;
  wire rDone    = s_axi_rvalid & s_axi_rready;
  wire rdCtrl   = (s_axi_araddr == CTRL_OFF);
  wire rdStatus = (s_axi_araddr == STATUS_OFF);

  wire [31:0] ctrlView = 32'(remoteMode_q) << CTRL_REMOTE_BIT;
  wire [OUT_W-1:0] outView = {coverLock, readyLamp, headsLoadReq, return_home_retract,
                              brake_ctl, retract_ctl, brake_power_ctl, motor_ctl,
                              speed_ok, start_ctl};
  wire [31:0] statusView = (32'(state_q) << STAT_STATE_LSB)
                         | (32'(outView) << STAT_OUT_LSB)
                         | (32'(pinSync) << STAT_PIN_LSB);
  wire [31:0] rdMux = rdCtrl ? ctrlView : (rdStatus ? statusView : 32'h0000_0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr_q      <= '0;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
    end else begin
      if (awTake) begin
        s_axi_awready <= 1'b0;
        awAddr_q      <= s_axi_awaddr;
      end
      if (wTake) begin
        s_axi_wready <= 1'b0;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end
      if (bDone) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register; the start bit is a self-clearing one-cycle press.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remoteMode_q <= CTRL_RST[CTRL_REMOTE_BIT];
      softStart_q  <= 1'b0;
    end else begin
      softStart_q <= wrCtrl & wStrb_q[0] & wData_q[CTRL_START_BIT];
      if (wrCtrl && wStrb_q[0]) begin
        remoteMode_q <= wData_q[CTRL_REMOTE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= (rdCtrl | rdStatus) ? RESP_OKAY : RESP_SLVERR;
    end else if (rDone) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// file: src/sync_bank.sv
/*
  Two-flop synchronisers, one per input bit.
  Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module sync_bank #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q   <= d[i];
          stable_q <= meta_q;
        end
      end
      assign q[i] = stable_q;
    end
  endgenerate

endmodule

// file: tb/spindle_plant.sv
/*
  Behavioural spindle, speed sensor and head carriage at the relay side.
  Assumes the bench clock; slow makes every change eight times slower.
*/
`timescale 1ns/1ps
module spindle_plant (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic motor_ctl,
  input  wire logic headsLoadReq,
  input  wire logic return_home_retract,
  output logic      speedSense,
  output logic      headsLoaded,
  output logic      headsUnloaded
);
  int spd = 0;
  int pos = 0;
  int tick = 0;
  always @(posedge clk) begin
    tick <= tick + 1;
    if (!slow || tick % 8 == 0) begin
      if (motor_ctl && spd < 12) spd <= spd + 1;
      else if (!motor_ctl && spd > 0) spd <= spd - 1;
      if (headsLoadReq && pos < 5) pos <= pos + 1;
      else if (return_home_retract && pos > 0) pos <= pos - 1;
    end
  end
  assign speedSense = spd >= 8;
  assign headsLoaded = pos == 5;
  assign headsUnloaded = pos == 0;
endmodule

// file: tb/spindle_power_sequencer_properties.sv
/*
  Checker of relay order and safety relations of the spindle sequencer.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module spindle_power_sequencer_properties (
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire logic [spindle_pkg::SUPPLY_W-1:0] supplyGood,
  input wire logic                             speedSense,
  input wire logic                             thermalOk,
  input wire logic                             start_ctl,
  input wire logic                             motor_ctl,
  input wire logic                             brake_power_ctl,
  input wire logic                             retract_ctl,
  input wire logic                             brake_ctl,
  input wire logic                             return_home_retract,
  input wire logic                             headsLoadReq,
  input wire logic                             readyLamp,
  input wire logic                             coverLock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_brake_order: assert property ($rose(brake_power_ctl) |-> !brake_ctl ##1 brake_ctl)
    else $error("brake relay not one cycle after brake power");
  a_brake_hold: assert property ($rose(brake_power_ctl) |-> brake_power_ctl [*8])
    else $error("brake power released too early");
  a_brake_release: assert property ($fell(brake_power_ctl) |->
      !brake_ctl && !coverLock && !readyLamp)
    else $error("lamp, lock or brake left on after braking");
  a_brake_motor_off: assert property (brake_power_ctl |-> !motor_ctl)
    else $error("motor powered while braking");
  a_unload_motor: assert property ($fell(return_home_retract) |-> !motor_ctl)
    else $error("motor kept after retraction ended");
  a_supply_retract: assert property ((!(&supplyGood)) [*5] |-> !retract_ctl)
    else $error("retract relay held after supply loss");
  a_speed_retract: assert property ((!speedSense) [*5] |-> !retract_ctl)
    else $error("retract relay held without speed");
  a_thermal_motor: assert property ((!thermalOk) [*5] |-> !motor_ctl)
    else $error("motor powered while overheated");
  a_lock_motor: assert property (motor_ctl |-> coverLock)
    else $error("cover unlocked while motor runs");
  a_rtz_start: assert property (return_home_retract |-> !start_ctl && !headsLoadReq)
    else $error("start or load active during retraction");
endmodule

// file: tb/spindle_power_sequencer_tb_top.sv
/*
  Self-checking bench of the spindle sequencer with a plant model.
  Assumes short timer parameters and an AXI4-Lite master in the bench.
*/
`timescale 1ns/1ps
module spindle_power_sequencer_tb_top;
  import spindle_pkg::*;
  localparam logic [31:0] LC = 32'h0000_0014;
  localparam logic [31:0] BL = 32'h0000_001E;
  logic       clk = 1'b0, rst_n = 1'b0, slow = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic       s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic       s_axi_arvalid = 0, s_axi_rready = 0;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic       startSw = 0, seqPowerReq = 1, breakersOk = 1, packOn = 1;
  logic       coverClosed = 1, thermalOk = 1, L;
  logic [2:0] supplyGood = 3'h7;
  logic       speedSense, headsLoaded, headsUnloaded, sequence_power_ctl, start_ctl;
  logic       speed_ok, motor_ctl, brake_power_ctl, retract_ctl, brake_ctl;
  logic       return_home_retract, headsLoadReq, readyLamp, coverLock;
  int         errorCnt = 0, nTests = 0, n, i, b, seed = 14;
  wire [9:0]  outs = {coverLock, readyLamp, headsLoadReq, return_home_retract, brake_ctl,
                      retract_ctl, brake_power_ctl, motor_ctl, speed_ok, start_ctl};
  always #20 clk = ~clk;
  spindle_power_sequencer #(.LOAD_CYC(LC), .BRAKE_LEN(BL), .FLASH_LEN(32'h0000_0004)) uut (.*);
  spindle_plant plant (.*);

  task finish_test;
    $display("checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (k == 100) begin
      chk("bus answer", 1, 0);
      finish_test();
    end
  endtask
  task wait_out(input int bit_i, input logic v);
    for (n = 0; n < 400 && outs[bit_i] !== v; n++) @(posedge clk);
    if (n == 400) begin
      chk($sformatf("output bit %0d", bit_i), 32'(v), 32'(outs[bit_i]));
      finish_test();
    end
  endtask
  task st(input seq_state_e e);
    axi(1'b0, STATUS_OFF, '0);
    chk("state", 32'(e), 32'(q[2:0]));
  endtask
  task press(input logic [31:0] v);
    if (v == 0) begin
      startSw <= 1'b1;
      step(4);
      startSw <= 1'b0;
    end else axi(1'b1, CTRL_OFF, v);
    step(4);
  endtask
  task up(input logic [31:0] v);
    press(v);
    wait_out(7, 1);
    step(14);
    st(ST_READY);
  endtask
  task down;
    wait_out(3, 1);
    chk("motor at braking", 0, 32'(motor_ctl));
    wait_out(3, 0);
    chk("brake time", 1, 32'(n >= BL - 1 && n <= BL + 1));
    chk("lamp and lock", 0, 32'({readyLamp, coverLock, brake_ctl}));
    st(ST_IDLE);
  endtask

  initial begin
    step(2);
    rst_n <= 1'b1;
    axi(1'b0, CTRL_OFF, '0);
    chk("ctrl reset", CTRL_RST, q);
    axi(1'b0, 8'h08, '0);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
    axi(1'b1, 8'h0C, 32'h0000_0002);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
    chk("outputs at reset", 0, 32'(outs));
    chk("sequence power", 1, 32'(sequence_power_ctl));
    for (i = 0; i < 4; i++) begin
      {breakersOk, packOn, coverClosed, thermalOk} <= ~(4'b1000 >> i);
      press(0);
      step(6);
      chk("start refused", 0, 32'(outs));
    end
    {breakersOk, packOn, coverClosed, thermalOk} <= 4'hF;
    $display("test refusals done");
    press(0);
    wait_out(2, 1);
    chk("lock with motor", 32'h0000_0003, 32'({start_ctl, coverLock}));
    wait_out(8, 1);
    wait_out(8, 0);
    wait_out(4, 1);
    chk("speed ok", 1, 32'(speed_ok));
    wait_out(7, 1);
    chk("load delay", 1, 32'(n >= LC - 1 && n <= LC + 4));
    wait_out(8, 1);
    step(50);
    st(ST_READY);
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      chk("lamp steady", 1, 32'(readyLamp));
    end
    press(0);
    wait_out(6, 1);
    chk("start dropped", 0, 32'(start_ctl));
    L = readyLamp;
    wait_out(8, !L);
    wait_out(8, L);
    down();
    wait_out(4, 0);
    chk("speed ok dropped", 0, 32'(speed_ok));
    $display("test local cycle done");
    slow <= 1'b0;
    seqPowerReq <= 1'b0;
    axi(1'b1, CTRL_OFF, 32'h0000_0001);
    press(32'h0000_0003);
    step(6);
    st(ST_IDLE);
    chk("remote power off", 0, 32'(sequence_power_ctl));
    seqPowerReq <= 1'b1;
    up(32'h0000_0003);
    chk("remote power on", 1, 32'(sequence_power_ctl));
    seqPowerReq <= 1'b0;
    wait_out(6, 1);
    chk("remote drop", 0, 32'(start_ctl));
    down();
    axi(1'b1, CTRL_OFF, '0);
    $display("test remote done");
    up(0);
    b = $unsigned($random(seed)) % 3;
    supplyGood[b] <= 1'b0;
    wait_out(4, 0);
    chk("supply retract", 1, 32'(n <= 6));
    down();
    supplyGood <= 3'h7;
    $display("test supply loss done");
    up(0);
    thermalOk <= 1'b0;
    wait_out(2, 0);
    chk("thermal motor", 1, 32'(n <= 6));
    down();
    press(0);
    step(8);
    chk("no restart hot", 0, 32'(motor_ctl));
    thermalOk <= 1'b1;
    $display("test thermal done");
    finish_test();
  end
endmodule
bind spindle_power_sequencer spindle_power_sequencer_properties chk (.*);
